// ### plk_checker.sv
// plk_checker: port-level properties of the lock and interrupt block
// assumes one clock domain, bound onto every plk_top instance
`timescale 1ns/1ps
module plk_checker (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic irq,
    input wire logic master_txn_end,
    input wire logic [7:0] retry_count,
    input wire logic master_active,
    input wire logic cycle_in_progress,
    input wire logic lock_n_out,
    input wire logic lock_n_oe,
    input wire logic master_locked,
    input wire logic tgt_access,
    input wire logic tgt_lock_start,
    input wire logic tgt_respond,
    input wire logic tgt_locked,
    input wire logic cpu_access_req,
    input wire logic cpu_access_grant
);
    // ==========================================================
    // properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    property p_rdz; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    a_rdz: assert property (p_rdz) else $error("read data outside slot");
    property p_irqfall; $fell(irq) |-> $past(reg_wr); endproperty
    a_irqfall: assert property (p_irqfall) else $error("irq fell without write");
    property p_drain; $fell(master_locked) |-> !$past(cycle_in_progress); endproperty
    a_drain: assert property (p_drain) else $error("lock dropped mid cycle");
    property p_idle; !master_active && !lock_n_oe |=> !lock_n_oe; endproperty
    a_idle: assert property (p_idle) else $error("lock driven as non master");
    property p_drive; lock_n_oe == !lock_n_out; endproperty
    a_drive: assert property (p_drive) else $error("lock pin level wrong");
    property p_tgt; $rose(tgt_locked) |-> $past(tgt_access && tgt_lock_start); endproperty
    a_tgt: assert property (p_tgt) else $error("target locked w/o attempt");
    property p_free; tgt_access && !tgt_locked |-> tgt_respond; endproperty
    a_free: assert property (p_free) else $error("free target ignored access");
    property p_cpu; cpu_access_grant == cpu_access_req; endproperty
    a_cpu: assert property (p_cpu) else $error("cpu access refused");
    property p_rty; master_txn_end |=> retry_count == 8'h00; endproperty
    a_rty: assert property (p_rty) else $error("retry count kept");
endmodule : plk_checker

bind plk_top plk_checker plk_checker_inst (.*);

// ### plk_if.sv
// plk_if: carriers between the top and its retry counter and status bank
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface plk_retry_if;
    logic retry;
    logic txn_end;
    logic [7:0] limit;
    logic hit;
    logic [7:0] count;
    modport owner (output retry, output txn_end, output limit, input hit, input count);
    modport counter (input retry, input txn_end, input limit, output hit, output count);
endinterface : plk_retry_if

interface plk_irq_if;
    logic [plk_pkg::NUM_CAUSE-1:0] event_set;
    logic [plk_pkg::NUM_CAUSE-1:0] clear;
    logic [plk_pkg::NUM_CAUSE-1:0] status;
    modport owner (output event_set, output clear, input status);
    modport bank (input event_set, input clear, output status);
endinterface : plk_irq_if

// ### plk_irq_bank.sv
// plk_irq_bank: sticky interrupt cause bits
// assumes clear pulses come from a register write, events are pulses
`timescale 1ns/1ps
module plk_irq_bank (
    input wire logic core_clk,
    input wire logic nrst,
    plk_irq_if.bank iif
);
    import plk_pkg::*;

    typedef struct packed {
        logic [NUM_CAUSE-1:0] status;
    } plk_ib_state_type;

    plk_ib_state_type st;
    plk_ib_state_type next_st;

    // ==========================================================
    // a new event wins over a clear in the same cycle
    always_comb begin
        next_st = st;
        for (int i = 0; i < NUM_CAUSE; i++) begin
            next_st.status[i] = iif.event_set[i] | (st.status[i] & ~iif.clear[i]);
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '{status: STATUS_RESET};
        end else begin
            st <= next_st;
        end
    end

    assign iif.status = st.status;
endmodule : plk_irq_bank

// ### plk_partner.sv
// plk_partner: other PCI agents on the bus seen from the lock logic
// assumes LOCK# is pulled up and driven low by any agent
`timescale 1ns/1ps
module plk_partner #(
    parameter int READY_DLY = 2
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic lock_n_out,
    input wire logic lock_n_oe,
    input wire logic other_lock,
    output logic lock_n_in,
    output logic target_lock_ready
);
    // ==========================================================
    // wire and target
    int wait_cnt;
    // pulled-up wire, low while any agent drives it low
    assign lock_n_in = !((lock_n_oe && !lock_n_out) || other_lock);
    // addressed target becomes lockable a few cycles after this agent starts driving LOCK# (lock_n_oe)
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wait_cnt <= 0;
        end else if (lock_n_oe) begin
            wait_cnt <= wait_cnt + 1;
        end else begin
            wait_cnt <= 0;
        end
    end
    assign target_lock_ready = wait_cnt >= READY_DLY;
endmodule : plk_partner

// ### plk_pkg.sv
// plk_pkg: shared constants and types of the lock and interrupt status block
// assumes a 32-bit register port with byte addresses and one 200 MHz clock
package plk_pkg;
    // ==========================================================
    // register map
    localparam logic [31:0] INT_STAT_OFFSET = 32'h0F00_0C28;
    localparam logic [31:0] EXCL_ACC_OFFSET = 32'h0F00_0C2C;
    // ==========================================================
    // interrupt cause positions inside the status byte
    localparam int NUM_CAUSE = 5;
    localparam int TAB_BIT = 0;
    localparam int MAB_BIT = 1;
    localparam int RTY_BIT = 2;
    localparam int SERR_BIT = 3;
    localparam int MBX_BIT = 4;
    localparam int STATUS_LSB = 0;
    localparam int MASK_LSB = 8;
    localparam int CLEAR_LSB = 24;
    // ==========================================================
    // exclusive access control fields
    localparam int EXCL_REQ_BIT = 0;
    localparam int UNLOCK_BIT = 1;
    // ==========================================================
    // reset values
    localparam logic [NUM_CAUSE-1:0] STATUS_RESET = 5'h00;
    localparam logic [NUM_CAUSE-1:0] MASK_RESET = 5'h1F;
    localparam logic EXCL_REQ_RESET = 1'b0;
    localparam logic UNLOCK_RESET = 1'b0;
    localparam logic [7:0] RETRY_COUNT_RESET = 8'h00;
    // ==========================================================
    // master side lock sequencer states
    typedef enum logic [1:0] {
        M_IDLE,
        M_REQ,
        M_LOCKED,
        M_DRAIN
    } plk_mstate_type;
endpackage : plk_pkg

// ### plk_retry_count.sv
// plk_retry_count: counts master retries of one transaction
// assumes retry and txn_end are one-cycle pulses from the master engine
`timescale 1ns/1ps
module plk_retry_count (
    input wire logic core_clk,
    input wire logic nrst,
    plk_retry_if.counter rif
);
    import plk_pkg::*;

    typedef struct packed {
        logic [7:0] count;
        logic hit;
    } plk_rc_state_type;

    plk_rc_state_type st;
    plk_rc_state_type next_st;

    // ==========================================================
    // count retries, pulse hit when the programmed limit is reached
    always_comb begin
        next_st = st;
        next_st.hit = 1'b0;
        if (rif.txn_end) begin
            next_st.count = RETRY_COUNT_RESET;
        end else if (rif.retry && (st.count != 8'hFF)) begin
            next_st.count = st.count + 8'h01;
            next_st.hit = (rif.limit != 8'h00) && (st.count + 8'h01 == rif.limit);
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '{count: RETRY_COUNT_RESET, hit: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign rif.hit = st.hit;
    assign rif.count = st.count;
endmodule : plk_retry_count

// ### plk_top.sv
// plk_top: exclusive access control and interrupt status of the PCI unit
// assumes all inputs synchronous to core_clk; LOCK# resolved outside
`timescale 1ns/1ps
module plk_top #(
    parameter int ID_W = 4
) (
    input wire logic core_clk,
    input wire logic nrst,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    // events from the PCI unit
    input wire logic mailbox_access,
    input wire logic serr_n_in,
    input wire logic master_retry,
    input wire logic master_txn_end,
    input wire logic master_abort_seen,
    input wire logic target_abort_seen,
    input wire logic [7:0] retry_limit_value,
    output logic [7:0] retry_count,
    // master side lock
    input wire logic master_active,
    input wire logic target_lock_ready,
    input wire logic cycle_in_progress,
    input wire logic lock_n_in,
    output logic lock_n_out,
    output logic lock_n_oe,
    output logic master_locked,
    // target side lock
    input wire logic tgt_access,
    input wire logic tgt_lock_start,
    input wire logic [ID_W-1:0] tgt_master_id,
    output logic tgt_respond,
    output logic tgt_locked,
    // CPU core path into the target
    input wire logic cpu_access_req,
    output logic cpu_access_grant
);
    import plk_pkg::*;

    // ==========================================================
    // state of the top level, cause status and retry count live in the submodules
    typedef struct packed {
        logic [NUM_CAUSE-1:0] mask;
        logic excl_req;
        logic unlock;
        plk_mstate_type mstate;
        logic lock_drive;
        logic tgt_locked;
        logic [ID_W-1:0] owner;
        logic serr_q;
        logic [31:0] rdata;
    } plk_top_state_type;

    plk_top_state_type st;
    plk_top_state_type next_st;

    plk_retry_if rif ();
    plk_irq_if iif ();

    logic int_wr;
    logic excl_wr;
    logic int_rd;
    logic excl_rd;
    logic serr_fall;
    logic bus_can_lock;
    logic [31:0] int_view;
    logic [31:0] excl_view;

    // ==========================================================
    // address decode
    function automatic logic reg_hit(input logic [31:0] addr, input logic [31:0] offset);
        reg_hit = (addr == offset);
    endfunction : reg_hit

    // strobes qualified by address
    assign int_wr = reg_wr & reg_hit(reg_addr, INT_STAT_OFFSET);
    assign excl_wr = reg_wr & reg_hit(reg_addr, EXCL_ACC_OFFSET);
    assign int_rd = reg_rd & reg_hit(reg_addr, INT_STAT_OFFSET);
    assign excl_rd = reg_rd & reg_hit(reg_addr, EXCL_ACC_OFFSET);

    // ==========================================================
    // event sources
    // SERR# seen going low since the last cycle
    assign serr_fall = st.serr_q & ~serr_n_in;

    // retry counter hookup
    assign rif.retry = master_retry;
    assign rif.txn_end = master_txn_end;
    assign rif.limit = retry_limit_value;

    plk_retry_count u_retry (
        .core_clk (core_clk),
        .nrst (nrst),
        .rif (rif)
    );

    // cause events into the sticky bank
    always_comb begin
        iif.event_set = '0;
        iif.event_set[MBX_BIT] = mailbox_access;
        iif.event_set[SERR_BIT] = serr_fall;
        iif.event_set[RTY_BIT] = rif.hit;
        iif.event_set[MAB_BIT] = master_abort_seen;
        iif.event_set[TAB_BIT] = target_abort_seen;
    end

    // write one to a clear bit drops the cause, zero does nothing
    always_comb begin
        iif.clear = '0;
        if (int_wr) begin
            iif.clear = reg_wdata[CLEAR_LSB +: NUM_CAUSE];
        end
    end

    plk_irq_bank u_bank (
        .core_clk (core_clk),
        .nrst (nrst),
        .iif (iif)
    );

    // ==========================================================
    // read views
    // status in the low byte, masks above, clear bits read zero
    always_comb begin
        int_view = 32'h0000_0000;
        int_view[STATUS_LSB +: NUM_CAUSE] = iif.status;
        int_view[MASK_LSB +: NUM_CAUSE] = st.mask;
    end

    // only the two control bits exist, the rest read zero
    always_comb begin
        excl_view = 32'h0000_0000;
        excl_view[EXCL_REQ_BIT] = st.excl_req;
        excl_view[UNLOCK_BIT] = st.unlock;
    end

    // ==========================================================
    // master side: LOCK# may be taken only when nobody holds it
    assign bus_can_lock = master_active & lock_n_in;

    // ==========================================================
    // next state
    always_comb begin
        next_st = st;

        // software writes
        if (int_wr) begin
            next_st.mask = reg_wdata[MASK_LSB +: NUM_CAUSE];
        end
        if (excl_wr) begin
            next_st.excl_req = reg_wdata[EXCL_REQ_BIT];
            next_st.unlock = reg_wdata[UNLOCK_BIT];
        end

        // read data valid the cycle after the strobe, zero elsewhere
        next_st.rdata = 32'h0000_0000;
        if (int_rd) begin
            next_st.rdata = int_view;
        end else if (excl_rd) begin
            next_st.rdata = excl_view;
        end

        // SERR# history for edge detection
        next_st.serr_q = serr_n_in;

        // master lock sequencer
        case (st.mstate)
            M_IDLE: begin
                if (st.excl_req && bus_can_lock) begin
                    next_st.mstate = M_REQ;
                end
            end
            M_REQ: begin
                if (!st.excl_req || !master_active) begin
                    next_st.mstate = M_IDLE;
                end else if (target_lock_ready) begin
                    next_st.mstate = M_LOCKED;
                end
            end
            M_LOCKED: begin
                if (!st.excl_req) begin
                    if (cycle_in_progress) begin
                        next_st.mstate = M_DRAIN;
                    end else begin
                        next_st.mstate = M_IDLE;
                    end
                end
            end
            M_DRAIN: begin
                if (!cycle_in_progress) begin
                    next_st.mstate = M_IDLE;
                end
            end
            default: begin
                next_st.mstate = M_IDLE;
            end
        endcase
        next_st.lock_drive = (next_st.mstate != M_IDLE);

        // target lock by a foreign master
        if (st.tgt_locked) begin
            // LOCK# released with no access under way ends the lock
            if ((lock_n_in && !tgt_access) || !st.unlock) begin
                next_st.tgt_locked = 1'b0;
            end
        end else if (tgt_access && tgt_lock_start && st.unlock) begin
            next_st.tgt_locked = 1'b1;
            next_st.owner = tgt_master_id;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '{mask: MASK_RESET,
                    excl_req: EXCL_REQ_RESET,
                    unlock: UNLOCK_RESET,
                    mstate: M_IDLE,
                    lock_drive: 1'b0,
                    tgt_locked: 1'b0,
                    owner: '0,
                    serr_q: 1'b1,
                    rdata: 32'h0000_0000};
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs
    // interrupt: any cause set and not masked
    assign irq = |(iif.status & ~st.mask);
    assign reg_rdata = st.rdata;
    assign retry_count = rif.count;

    // LOCK# driven low while the sequencer holds it
    assign lock_n_out = ~st.lock_drive;
    assign lock_n_oe = st.lock_drive;
    assign master_locked = (st.mstate == M_LOCKED) || (st.mstate == M_DRAIN);

    // foreign accesses filtered by the lock owner
    assign tgt_locked = st.tgt_locked;
    assign tgt_respond = tgt_access & (~st.tgt_locked | (tgt_master_id == st.owner));

    // the CPU core is never shut out by a PCI lock
    assign cpu_access_grant = cpu_access_req;

endmodule : plk_top

// ### testbench.sv
// testbench: registers, interrupt causes, master and target locking
// assumes plk_top, plk_partner and the bound checker are compiled
`timescale 1ns/1ps
module testbench;
    import plk_pkg::*;
    // ==========================================================
    // signals
    logic core_clk, nrst, reg_wr, reg_rd, irq, mailbox_access, serr_n_in;
    logic master_retry, master_txn_end, master_abort_seen, target_abort_seen;
    logic master_active, target_lock_ready, cycle_in_progress, lock_n_in;
    logic lock_n_out, lock_n_oe, master_locked, tgt_access, tgt_lock_start;
    logic tgt_respond, tgt_locked, cpu_access_req, cpu_access_grant, other_lock;
    logic [31:0] reg_addr, reg_wdata, reg_rdata;
    logic [7:0] retry_limit_value, retry_count;
    logic [3:0] tgt_master_id;
    int bad_count, checks_done;
    plk_top #(.ID_W(4)) plk_top_inst (.*);
    plk_partner plk_partner_inst (.*);
    // ==========================================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask : rd
    task automatic pulse(input int i);
        @(posedge core_clk);
        target_abort_seen <= (i == TAB_BIT);
        master_abort_seen <= (i == MAB_BIT);
        master_retry <= (i == RTY_BIT);
        serr_n_in <= (i != SERR_BIT);
        mailbox_access <= (i == MBX_BIT);
        @(posedge core_clk);
        // drop every cause after exactly one sampled cycle
        {target_abort_seen, master_abort_seen, master_retry, mailbox_access} <= 4'h0;
        serr_n_in <= 1'b1;
    endtask : pulse
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    // ==========================================================
    // scenarios
    task automatic t_reset;
        rd(INT_STAT_OFFSET, 32'h0000_1F00);
        rd(EXCL_ACC_OFFSET, 32'h0);
        rd(32'h0F00_0C30, 32'h0);
        wr(EXCL_ACC_OFFSET, 32'h0000_0003);
        rd(EXCL_ACC_OFFSET, 32'h3);
        chk(lock_n_oe, 1'b0);
        wr(EXCL_ACC_OFFSET, 32'h0);
    endtask : t_reset
    task automatic t_irq;
        retry_limit_value <= 8'h02;
        wr(INT_STAT_OFFSET, 32'h0);
        for (int i = 0; i < NUM_CAUSE; i++) begin
            pulse(i);
            if (i == RTY_BIT) pulse(i);
            rd(INT_STAT_OFFSET, 32'h1 << i);
            chk(irq, 1'b1);
            wr(INT_STAT_OFFSET, 32'h1 << (CLEAR_LSB + i));
            rd(INT_STAT_OFFSET, 32'h0);
            chk(irq, 1'b0);
        end
        pulse(-1);
        master_txn_end <= 1'b1;
        tick(1);
        master_txn_end <= 1'b0;
        tick(1);
        chk(retry_count, 8'h00);
    endtask : t_irq
    task automatic t_mask;
        wr(INT_STAT_OFFSET, 32'h0000_0200);
        pulse(MAB_BIT);
        rd(INT_STAT_OFFSET, 32'h0000_0202);
        chk(irq, 1'b0);
        wr(INT_STAT_OFFSET, 32'h0200_0000);
        rd(INT_STAT_OFFSET, 32'h0);
    endtask : t_mask
    task automatic t_master;
        other_lock <= 1'b1;
        master_active <= 1'b1;
        wr(EXCL_ACC_OFFSET, 32'h1);
        tick(4);
        chk(lock_n_oe, 1'b0);
        other_lock <= 1'b0;
        for (int n = 0; n < 20 && master_locked !== 1'b1; n++) tick(1);
        chk(lock_n_out, 1'b0);
        chk(master_locked, 1'b1);
        cycle_in_progress <= 1'b1;
        wr(EXCL_ACC_OFFSET, 32'h0);
        tick(3);
        chk(master_locked, 1'b1);
        cycle_in_progress <= 1'b0;
        tick(3);
        chk(lock_n_oe, 1'b0);
        master_active <= 1'b0;
    endtask : t_master
    task automatic t_target;
        tgt_access <= 1'b1;
        tgt_lock_start <= 1'b1;
        tgt_master_id <= 4'h3;
        tick(2);
        chk(tgt_locked, 1'b0);
        wr(EXCL_ACC_OFFSET, 32'h2);
        tick(2);
        chk(tgt_locked, 1'b1);
        tgt_lock_start <= 1'b0;
        tgt_master_id <= 4'h5;
        cpu_access_req <= 1'b1;
        tick(1);
        chk(tgt_respond, 1'b0);
        chk(cpu_access_grant, 1'b1);
        tgt_master_id <= 4'h3;
        tick(1);
        chk(tgt_respond, 1'b1);
        tgt_access <= 1'b0;
        cpu_access_req <= 1'b0;
        tick(2);
        chk(tgt_locked, 1'b0);
        // lock again, then withdraw permission while the lock is held
        tgt_access <= 1'b1;
        tgt_lock_start <= 1'b1;
        tick(2);
        chk(tgt_locked, 1'b1);
        wr(EXCL_ACC_OFFSET, 32'h0);
        tick(1);
        chk(tgt_locked, 1'b0);
        {tgt_access, tgt_lock_start} <= 2'b00;
    endtask : t_target
    // ==========================================================
    // verdict, clock, sequence and watchdog
    task automatic print_verdict;
        $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        {nrst, reg_wr, reg_rd, mailbox_access, master_retry, master_txn_end} = '0;
        {master_abort_seen, target_abort_seen, master_active, other_lock} = '0;
        {cycle_in_progress, tgt_access, tgt_lock_start, cpu_access_req} = '0;
        {reg_addr, reg_wdata, retry_limit_value, tgt_master_id} = '0;
        serr_n_in = 1'b1;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset;
        t_irq;
        t_mask;
        t_master;
        t_target;
        print_verdict;
    end
    initial begin
        #50000;
        bad_count++;
        print_verdict;
    end
endmodule : testbench
